// ===== verilog/ptc_pkg.sv
// ptc_pkg: register map, field layout, reset values and timing counts for protocol timing config
`default_nettype none
package ptc_pkg;
   // ======================================================================
   // register offsets
   localparam logic [7:0] COMM_TIMING_OFF = 8'h22;
   localparam logic [7:0] CHIP_BIT_OFF = 8'h23;
   localparam logic [7:0] SRC_ZERO_OFF = 8'h1A;
   localparam logic [7:0] SRC_ONE_OFF = 8'h1B;
   // ======================================================================
   // reset values
   localparam logic [7:0] COMM_TIMING_RST = 8'h00;
   localparam logic [7:0] CHIP_BIT_RST = 8'h00;
   localparam logic [7:0] SRC_RST = 8'h00;
   // ======================================================================
   // field positions
   localparam int CAL_EN_BIT = 0;
   localparam int CRM_LSB = 1;
   localparam int CAL_RST_BIT = 3;
   localparam int TRAIN_SEL_BIT = 4;
   localparam int PERIOD_LSB = 5;
   localparam int CHIP_LSB = 0;
   localparam int SS_EN_BIT = 4;
   localparam int SRC_EN_BIT = 7;
   // ======================================================================
   // protocol type codes
   localparam logic [3:0] PROTO_DSI3 = 4'h0;
   localparam logic [3:0] PROTO_PSI5 = 4'h1;
   // ======================================================================
   // timing: clock rate and periods
   localparam int CLK_MHZ = 250;
   localparam int PERIOD_US_0 = 100;
   localparam int PERIOD_US_1 = 125;
   localparam int PERIOD_US_2 = 250;
   localparam int PERIOD_US_3 = 333;
   localparam int PERIOD_US_4 = 500;
   localparam int PERIOD_US_5 = 800;
   localparam int PERIOD_US_6 = 1000;
   localparam int PERIOD_US_7 = 2000;
   localparam int BIT_NS_FAST = 5300;
   localparam int BIT_NS_SLOW = 8000;
   localparam int BIT_CYC_FAST = BIT_NS_FAST * CLK_MHZ / 1000;
   localparam int BIT_CYC_SLOW = BIT_NS_SLOW * CLK_MHZ / 1000;
   localparam logic [3:0] CHIP_SLOW_MIN = 4'h8;
   // ======================================================================
   // types
   typedef enum logic [1:0] {PTC_ASYNC, PTC_SYNC, PTC_DAISY} ptc_tx_mode_t;
   typedef enum logic [1:0] {PTC_HOLD, PTC_TRAIN, PTC_DEFAULT} ptc_osc_t;
endpackage : ptc_pkg
`default_nettype wire

// ===== verilog/ptc_src_sched.sv
// ptc_src_sched: psi5 source word selection per transmission mode
`timescale 1ns/1ns
`default_nettype none
module ptc_src_sched (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic psi5_i,
   input wire ptc_pkg::ptc_tx_mode_t mode_i,
   input wire logic src0_en_i,
   input wire logic src1_en_i,
   input wire logic async_tick_i,
   input wire logic start0_tick_i,
   input wire logic start1_tick_i,
   input wire logic daisy_tick_i,
   output logic send_zero_o,
   output logic send_one_o
);
   // ======================================================================
   // send decision
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         send_zero_o <= 1'b0;
         send_one_o <= 1'b0;
      end else begin
         send_zero_o <= 1'b0;
         send_one_o <= 1'b0;
         if (psi5_i) begin
            case (mode_i)
               ptc_pkg::PTC_ASYNC: begin
                  send_zero_o <= async_tick_i;
               end
               ptc_pkg::PTC_SYNC: begin
                  send_zero_o <= src0_en_i & start0_tick_i;
                  send_one_o <= src1_en_i & start1_tick_i;
               end
               ptc_pkg::PTC_DAISY: begin
                  send_zero_o <= daisy_tick_i;
               end
               default: begin
                  send_zero_o <= 1'b0;
               end
            endcase
         end
      end
   end

   a_async_no_one: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (psi5_i && mode_i == ptc_pkg::PTC_ASYNC) |=> !send_one_o)
      else $error("source one sent in async mode");
   a_sync_disabled: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (psi5_i && mode_i == ptc_pkg::PTC_SYNC && !src0_en_i) |=> !send_zero_o)
      else $error("disabled source zero sent");
endmodule : ptc_src_sched
`default_nettype wire

// ===== verilog/ptc_timing_cfg.sv
// ptc_timing_cfg: timing and chip time configuration registers with oscillator training control
//
// Function
// - psi5 sends source words per mode: async, sync or daisy chain
// - timing register read/write at 0x22, parity protected
// - timing register accessible only in dsi3 or psi5 diagnostic mode
// - period code bits 7:5 selects 100 to 2000 us
// - period used only for training, only with calibration enabled
// - dsi3 collection commands answered whatever timing register holds
// - psi5 sync pulses answered whatever timing register holds
// - no training in psi5 async, diagnostic, or daisy command phase
// - select 0 trains dsi3 for type 0, psi5 for type 1, else none
// - cmd/resp period bits 2:1 gives 1,2,4,8 collection periods
// - in psi5 cmd/resp field stored but unused
// - calibration enable trains oscillator regardless of reset bit
// - disabled, reset 0: hold last trained value
// - disabled, reset 1: return to untrained default
// - chip time register at 0x23: bit 4 simultaneous, bits 3:0 chip code
// - chip time register accessible only in psi5 diagnostic mode
// - psi5 chip codes 0-7 give 5.3 us, 8-15 give 8.0 us
// - simultaneous bit 0 latency from slot, 1 from sync pulse
`timescale 1ns/1ns
`default_nettype none
module ptc_timing_cfg #(
   parameter int ADDR_W = 8,
   parameter int DATA_W = 8
) (
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic [ADDR_W-1:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [DATA_W-1:0] reg_wdata_i,
   input wire logic [3:0] protocol_type_i,
   input wire logic psi5_diag_i,
   input wire logic psi5_daisy_cmd_i,
   input wire ptc_pkg::ptc_tx_mode_t psi5_mode_i,
   input wire logic async_tick_i,
   input wire logic start0_tick_i,
   input wire logic start1_tick_i,
   input wire logic daisy_tick_i,
   input wire logic frame_pulse_i,
   output logic [DATA_W-1:0] reg_rdata_o,
   output logic reg_rvalid_o,
   output logic reg_denied_o,
   output logic parity_err_o,
   output logic train_active_o,
   output logic train_psi5_o,
   output logic osc_reset_o,
   output logic [3:0] osc_trim_o,
   output logic [2:0] collection_period_code_o,
   output logic [3:0] period_mult_o,
   output logic [12:0] bit_cycles_o,
   output logic sync_latency_o,
   output logic send_zero_o,
   output logic send_one_o
);
   // ======================================================================
   // elaboration checks
   if (DATA_W != 8) begin : g_bad_data_w
      $error("data width must be 8");
   end
   if (ADDR_W < 6) begin : g_bad_addr_w
      $error("address width too small");
   end

   // ======================================================================
   // helpers
   function automatic logic parity8(input logic [7:0] v);
      parity8 = ^v;
   endfunction : parity8

   logic is_dsi3;
   logic is_psi5;
   logic hit_timing;
   logic hit_chip;
   logic hit_src0;
   logic hit_src1;
   logic allow_timing;
   logic allow_chip;
   assign is_dsi3 = protocol_type_i == ptc_pkg::PROTO_DSI3;
   assign is_psi5 = protocol_type_i == ptc_pkg::PROTO_PSI5;
   assign hit_timing = reg_addr_i == ADDR_W'(ptc_pkg::COMM_TIMING_OFF);
   assign hit_chip = reg_addr_i == ADDR_W'(ptc_pkg::CHIP_BIT_OFF);
   assign hit_src0 = reg_addr_i == ADDR_W'(ptc_pkg::SRC_ZERO_OFF);
   assign hit_src1 = reg_addr_i == ADDR_W'(ptc_pkg::SRC_ONE_OFF);
   assign allow_timing = is_dsi3 | (is_psi5 & psi5_diag_i);
   assign allow_chip = is_psi5 & psi5_diag_i;

   // ======================================================================
   // registers with parity
   logic [7:0] comm_timing_config_q;
   logic [7:0] chip_bit_time_config_q;
   logic [7:0] source_ident_zero_q;
   logic [7:0] source_ident_one_q;
   logic [3:0] par_q;

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         comm_timing_config_q <= ptc_pkg::COMM_TIMING_RST;
         chip_bit_time_config_q <= ptc_pkg::CHIP_BIT_RST;
         source_ident_zero_q <= ptc_pkg::SRC_RST;
         source_ident_one_q <= ptc_pkg::SRC_RST;
         par_q <= 4'h0;
      end else if (reg_wr_i && allow_timing) begin
         if (hit_timing) begin
            comm_timing_config_q <= reg_wdata_i;
            par_q[0] <= parity8(reg_wdata_i);
         end
         if (hit_src0) begin
            source_ident_zero_q <= reg_wdata_i;
            par_q[2] <= parity8(reg_wdata_i);
         end
         if (hit_src1) begin
            source_ident_one_q <= reg_wdata_i;
            par_q[3] <= parity8(reg_wdata_i);
         end
         if (hit_chip && allow_chip) begin
            chip_bit_time_config_q <= reg_wdata_i;
            par_q[1] <= parity8(reg_wdata_i);
         end
      end
   end

   // ======================================================================
   // read path
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         reg_rdata_o <= 8'h00;
         reg_rvalid_o <= 1'b0;
         reg_denied_o <= 1'b0;
      end else begin
         reg_rvalid_o <= 1'b0;
         reg_denied_o <= 1'b0;
         reg_rdata_o <= 8'h00;
         if (reg_rd_i || reg_wr_i) begin
            if (hit_chip) begin
               reg_denied_o <= !allow_chip;
            end else if (hit_timing || hit_src0 || hit_src1) begin
               reg_denied_o <= !allow_timing;
            end
         end
         if (reg_rd_i) begin
            reg_rvalid_o <= 1'b1;
            if (hit_timing && allow_timing) begin
               reg_rdata_o <= comm_timing_config_q;
            end else if (hit_chip && allow_chip) begin
               reg_rdata_o <= chip_bit_time_config_q;
            end else if (hit_src0 && allow_timing) begin
               reg_rdata_o <= source_ident_zero_q;
            end else if (hit_src1 && allow_timing) begin
               reg_rdata_o <= source_ident_one_q;
            end
         end
      end
   end

   // array check
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         parity_err_o <= 1'b0;
      end else begin
         parity_err_o <= (parity8(comm_timing_config_q) != par_q[0]) |
            (parity8(chip_bit_time_config_q) != par_q[1]) |
            (parity8(source_ident_zero_q) != par_q[2]) |
            (parity8(source_ident_one_q) != par_q[3]);
      end
   end

   // ======================================================================
   // oscillator training control
   logic cal_en;
   logic cal_rst;
   logic train_sel;
   logic train_ok;
   logic train_proto;
   assign cal_en = comm_timing_config_q[ptc_pkg::CAL_EN_BIT];
   assign cal_rst = comm_timing_config_q[ptc_pkg::CAL_RST_BIT];
   assign train_sel = comm_timing_config_q[ptc_pkg::TRAIN_SEL_BIT];
   assign train_proto = !train_sel & (is_dsi3 | is_psi5);
   assign train_ok = is_dsi3 | (is_psi5 & !psi5_diag_i & !psi5_daisy_cmd_i &
      psi5_mode_i != ptc_pkg::PTC_ASYNC);

   ptc_pkg::ptc_osc_t osc_q;
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         osc_q <= ptc_pkg::PTC_HOLD;
         osc_trim_o <= 4'h0;
      end else begin
         case ({cal_en, cal_rst})
            2'b10, 2'b11: begin
               osc_q <= ptc_pkg::PTC_TRAIN;
               if (train_ok && train_proto && frame_pulse_i) begin
                  osc_trim_o <= osc_trim_o + 4'h1;
               end
            end
            2'b01: begin
               osc_q <= ptc_pkg::PTC_DEFAULT;
               osc_trim_o <= 4'h0;
            end
            2'b00: begin
               osc_q <= ptc_pkg::PTC_HOLD;
            end
            default: begin
               osc_q <= ptc_pkg::PTC_HOLD;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         train_active_o <= 1'b0;
         train_psi5_o <= 1'b0;
         osc_reset_o <= 1'b0;
         collection_period_code_o <= 3'h0;
         period_mult_o <= 4'h1;
      end else begin
         train_active_o <= cal_en & train_ok & train_proto;
         train_psi5_o <= train_proto & is_psi5;
         osc_reset_o <= osc_q == ptc_pkg::PTC_DEFAULT;
         // period code only presented while calibration enabled
         collection_period_code_o <= cal_en ? comm_timing_config_q[ptc_pkg::PERIOD_LSB +: 3] : 3'h0;
         // multiple only meaningful in dsi3
         period_mult_o <= is_dsi3 ? 4'(4'h1 << comm_timing_config_q[ptc_pkg::CRM_LSB +: 2]) : 4'h1;
      end
   end

   // ======================================================================
   // chip time and latency
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         bit_cycles_o <= 13'(ptc_pkg::BIT_CYC_FAST);
         sync_latency_o <= 1'b0;
      end else begin
         bit_cycles_o <= (chip_bit_time_config_q[ptc_pkg::CHIP_LSB +: 4] >= ptc_pkg::CHIP_SLOW_MIN) ?
            13'(ptc_pkg::BIT_CYC_SLOW) : 13'(ptc_pkg::BIT_CYC_FAST);
         sync_latency_o <= is_psi5 & chip_bit_time_config_q[ptc_pkg::SS_EN_BIT];
      end
   end

   // ======================================================================
   // psi5 source scheduling; sync and collection answered independent of timing config
   ptc_src_sched u_sched (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .psi5_i(is_psi5),
      .mode_i(psi5_mode_i),
      .src0_en_i(source_ident_zero_q[ptc_pkg::SRC_EN_BIT]),
      .src1_en_i(source_ident_one_q[ptc_pkg::SRC_EN_BIT]),
      .async_tick_i(async_tick_i),
      .start0_tick_i(start0_tick_i),
      .start1_tick_i(start1_tick_i),
      .daisy_tick_i(daisy_tick_i),
      .send_zero_o(send_zero_o),
      .send_one_o(send_one_o)
   );

   // ======================================================================
   // checks
   a_chip_locked: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (reg_wr_i && hit_chip && !allow_chip) |=> $stable(chip_bit_time_config_q))
      else $error("chip time written outside diagnostic mode");
   a_timing_locked: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (reg_wr_i && hit_timing && !allow_timing) |=> $stable(comm_timing_config_q))
      else $error("timing written while locked");
   a_timing_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (reg_wr_i && hit_timing && allow_timing) |=> comm_timing_config_q == $past(reg_wdata_i))
      else $error("timing write lost");
   a_no_train_async: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (is_psi5 && psi5_mode_i == ptc_pkg::PTC_ASYNC) |=> !train_active_o)
      else $error("training in async mode");
   a_default_trim: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (!cal_en && cal_rst) |=> osc_trim_o == 4'h0)
      else $error("trim not reset");
   a_hold_trim: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (!cal_en && !cal_rst && !$past(cal_en)) |=> $stable(osc_trim_o))
      else $error("trim changed while held");
   a_period_gate: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !cal_en |=> collection_period_code_o == 3'h0)
      else $error("period used without calibration");
   a_bit_time: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      chip_bit_time_config_q[3] |=> bit_cycles_o == 13'(ptc_pkg::BIT_CYC_SLOW))
      else $error("slow bit time wrong");
   a_sel_proto: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (train_sel || (!is_dsi3 && !is_psi5)) |=> !train_active_o)
      else $error("training with select set");
   a_read_denied: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (reg_rd_i && hit_chip && !allow_chip) |=> (reg_rvalid_o && reg_denied_o && reg_rdata_o == '0))
      else $error("locked chip time read not refused");
   a_trim_advance: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (cal_en && train_ok && train_proto && frame_pulse_i) |=> osc_trim_o == 4'($past(osc_trim_o) + 4'h1))
      else $error("trim did not advance while training");
   a_osc_default: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (!cal_en && cal_rst) |-> ##2 osc_reset_o)
      else $error("oscillator not returned to default");
   a_mult_psi5: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !is_dsi3 |=> period_mult_o == 4'h1)
      else $error("cmd resp period used outside dsi3");
   a_sync_answer: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (is_psi5 && psi5_mode_i == ptc_pkg::PTC_SYNC && source_ident_zero_q[ptc_pkg::SRC_EN_BIT] &&
      start0_tick_i) |=> send_zero_o)
      else $error("sync pulse not answered");
endmodule : ptc_timing_cfg
`default_nettype wire

// ===== tb/ptc_master_model.sv
// ptc_master_model: bus master model issuing register accesses, ticks and frame pulses
`timescale 1ns/1ns
`default_nettype none
module ptc_master_model (
   input wire logic clk_i,
   input wire logic [7:0] reg_rdata_i,
   input wire logic reg_rvalid_i,
   input wire logic reg_denied_i,
   output logic [7:0] reg_addr_o,
   output logic reg_wr_o,
   output logic reg_rd_o,
   output logic [7:0] reg_wdata_o,
   output logic [3:0] tick_o,
   output logic frame_pulse_o
);
   // ======================================================================
   // idle state
   initial begin
      reg_addr_o = 8'h00;
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      reg_wdata_o = 8'h00;
      tick_o = 4'h0;
      frame_pulse_o = 1'b0;
   end
   // ======================================================================
   // register write, one byte, released bus shows inverted value
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      reg_addr_o <= a;
      reg_wdata_o <= d;
      reg_wr_o <= 1'b1;
      @(posedge clk_i);
      reg_wr_o <= 1'b0;
      reg_addr_o <= ~a;
      reg_wdata_o <= ~d;
   endtask : wr
   // ======================================================================
   // register read, answer taken one cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v, output logic dn);
      @(posedge clk_i);
      reg_addr_o <= a;
      reg_rd_o <= 1'b1;
      @(posedge clk_i);
      reg_rd_o <= 1'b0;
      reg_addr_o <= ~a;
      #1;
      d = reg_rdata_i;
      v = reg_rvalid_i;
      dn = reg_denied_i;
   endtask : rd
   // ======================================================================
   // timing ticks: 0 async, 1 start zero, 2 start one, 3 daisy
   task automatic pulse(input int idx);
      @(posedge clk_i);
      tick_o[idx] <= 1'b1;
      @(posedge clk_i);
      tick_o <= 4'h0;
   endtask : pulse
   task automatic frames(input int n);
      repeat (n) begin
         @(posedge clk_i);
         frame_pulse_o <= 1'b1;
         @(posedge clk_i);
         frame_pulse_o <= 1'b0;
      end
   endtask : frames
endmodule : ptc_master_model
`default_nettype wire

// ===== tb/ptc_timing_cfg_tb_top.sv
// ptc_timing_cfg_tb_top: self-checking bench for the timing configuration block
`timescale 1ns/1ns
`default_nettype none
module ptc_timing_cfg_tb_top;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [7:0] reg_addr, reg_wdata, rdata;
   logic reg_wr, reg_rd, rvalid, denied, frame_pulse, szero, sone, train, tpsi5, oscrst, ssl, perr;
   logic [3:0] ticks, trim, mult;
   logic [3:0] protocol_type_i = 4'h0;
   logic psi5_diag_i = 1'b0;
   logic psi5_daisy_cmd_i = 1'b0;
   ptc_pkg::ptc_tx_mode_t psi5_mode_i = ptc_pkg::PTC_SYNC;
   logic [2:0] cpc;
   logic [12:0] bitc;
   int mismatches = 0;
   int total_checks = 0;
   // ======================================================================
   // clock, reset and instances
   initial begin
      forever #2 clk_i = ~clk_i;
   end
   ptc_master_model m (.clk_i(clk_i), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid), .reg_denied_i(denied),
      .reg_addr_o(reg_addr), .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_wdata_o(reg_wdata), .tick_o(ticks),
      .frame_pulse_o(frame_pulse));
   ptc_timing_cfg dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr), .reg_wr_i(reg_wr),
      .reg_rd_i(reg_rd), .reg_wdata_i(reg_wdata), .protocol_type_i(protocol_type_i), .psi5_diag_i(psi5_diag_i),
      .psi5_daisy_cmd_i(psi5_daisy_cmd_i), .psi5_mode_i(psi5_mode_i), .async_tick_i(ticks[0]),
      .start0_tick_i(ticks[1]), .start1_tick_i(ticks[2]), .daisy_tick_i(ticks[3]), .frame_pulse_i(frame_pulse),
      .reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .reg_denied_o(denied), .parity_err_o(perr), .train_active_o(train),
      .train_psi5_o(tpsi5), .osc_reset_o(oscrst), .osc_trim_o(trim), .collection_period_code_o(cpc),
      .period_mult_o(mult), .bit_cycles_o(bitc), .sync_latency_o(ssl), .send_zero_o(szero), .send_one_o(sone));
   // ======================================================================
   // helpers
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic settle();
      repeat (3) @(posedge clk_i);
      #1;
   endtask : settle
   task automatic md(input logic [3:0] t, input logic g, input logic c, input ptc_pkg::ptc_tx_mode_t mo);
      @(posedge clk_i);
      protocol_type_i <= t;
      psi5_diag_i <= g;
      psi5_daisy_cmd_i <= c;
      psi5_mode_i <= mo;
      settle();
   endtask : md
   task automatic wrs(input logic [7:0] a, input logic [7:0] d);
      m.wr(a, d);
      settle();
   endtask : wrs
   task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input logic dn_exp);
      logic [7:0] d;
      logic v, dn;
      m.rd(a, d, v, dn);
      chk({v, dn, d}, {1'b1, dn_exp, exp});
   endtask : rdc
   task automatic tk(input int idx, input logic e0, input logic e1);
      int c0, c1;
      c0 = 0;
      c1 = 0;
      m.pulse(idx);
      for (int k = 0; k < 3; k++) begin
         #1;
         c0 += int'(szero);
         c1 += int'(sone);
         @(posedge clk_i);
      end
      chk({c0[7:0], c1[7:0]}, {7'h00, e0, 7'h00, e1});
   endtask : tk
   // ======================================================================
   // scenarios
   task automatic t_access();
      chk({bitc, mult}, {13'd1325, 4'h1});
      rdc(8'h22, 8'h00, 1'b0);
      wrs(8'h22, 8'hA6);
      rdc(8'h22, 8'hA6, 1'b0);
      wrs(8'h23, 8'h15);
      rdc(8'h23, 8'h00, 1'b1);
      md(4'h1, 1'b0, 1'b0, ptc_pkg::PTC_SYNC);
      rdc(8'h22, 8'h00, 1'b1);
      wrs(8'h22, 8'h00);
      md(4'h1, 1'b1, 1'b0, ptc_pkg::PTC_SYNC);
      rdc(8'h22, 8'hA6, 1'b0);
      wrs(8'h23, 8'h15);
      rdc(8'h23, 8'h15, 1'b0);
      rdc(8'h30, 8'h00, 1'b0);
      chk(perr, 1'b0);
   endtask : t_access
   task automatic t_reset();
      md(4'h0, 1'b0, 1'b0, ptc_pkg::PTC_SYNC);
      @(posedge clk_i);
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      #1;
      chk(trim, 4'h0);
      chk(bitc, 13'd1325);
      rdc(8'h22, 8'h00, 1'b0);
   endtask : t_reset
   task automatic t_period();
      md(4'h0, 1'b0, 1'b0, ptc_pkg::PTC_SYNC);
      for (int c = 0; c < 8; c++) begin
         wrs(8'h22, {c[2:0], 5'h00});
         chk(cpc, 3'h0);
         wrs(8'h22, {c[2:0], 5'h01});
         chk(cpc, c[2:0]);
      end
      for (int c = 0; c < 4; c++) begin
         md(4'h0, 1'b0, 1'b0, ptc_pkg::PTC_SYNC);
         wrs(8'h22, {5'h00, c[1:0], 1'b0});
         chk(mult, 4'h1 << c);
         md(4'h1, 1'b1, 1'b0, ptc_pkg::PTC_SYNC);
         chk(mult, 4'h1);
      end
   endtask : t_period
   task automatic t_train();
      md(4'h0, 1'b0, 1'b0, ptc_pkg::PTC_SYNC);
      wrs(8'h22, 8'h08);
      chk({oscrst, trim}, {1'b1, 4'h0});
      wrs(8'h22, 8'h09);
      chk({train, tpsi5}, 2'b10);
      m.frames(3);
      wrs(8'h22, 8'h01);
      chk({train, tpsi5, trim}, {2'b10, 4'h3});
      wrs(8'h22, 8'h00);
      m.frames(2);
      settle();
      chk({train, oscrst, trim}, {2'b00, 4'h3});
      wrs(8'h22, 8'h11);
      chk(train, 1'b0);
      wrs(8'h22, 8'h01);
      md(4'h2, 1'b0, 1'b0, ptc_pkg::PTC_SYNC);
      chk(train, 1'b0);
      md(4'h1, 1'b0, 1'b0, ptc_pkg::PTC_SYNC);
      chk({train, tpsi5}, 2'b11);
      md(4'h1, 1'b0, 1'b0, ptc_pkg::PTC_ASYNC);
      chk(train, 1'b0);
      md(4'h1, 1'b0, 1'b1, ptc_pkg::PTC_SYNC);
      chk(train, 1'b0);
      md(4'h1, 1'b1, 1'b0, ptc_pkg::PTC_SYNC);
      chk(train, 1'b0);
   endtask : t_train
   task automatic t_chip_sched();
      wrs(8'h23, 8'h07);
      chk({bitc, ssl}, {13'd1325, 1'b0});
      wrs(8'h23, 8'h18);
      chk({bitc, ssl}, {13'd2000, 1'b1});
      wrs(8'h1A, 8'h80);
      wrs(8'h1B, 8'h00);
      md(4'h1, 1'b0, 1'b0, ptc_pkg::PTC_ASYNC);
      tk(0, 1'b1, 1'b0);
      tk(2, 1'b0, 1'b0);
      md(4'h1, 1'b0, 1'b0, ptc_pkg::PTC_SYNC);
      tk(1, 1'b1, 1'b0);
      tk(2, 1'b0, 1'b0);
      md(4'h1, 1'b0, 1'b0, ptc_pkg::PTC_DAISY);
      tk(3, 1'b1, 1'b0);
      md(4'h1, 1'b1, 1'b0, ptc_pkg::PTC_SYNC);
      wrs(8'h1A, 8'h00);
      wrs(8'h1B, 8'h80);
      md(4'h1, 1'b0, 1'b0, ptc_pkg::PTC_SYNC);
      tk(1, 1'b0, 1'b0);
      tk(2, 1'b0, 1'b1);
   endtask : t_chip_sched
   // ======================================================================
   // main sequence and watchdog
   initial begin
      repeat (5) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      #1;
      t_access();
      t_period();
      t_train();
      t_chip_sched();
      t_reset();
      print_verdict();
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      mismatches++;
      print_verdict();
   end
endmodule : ptc_timing_cfg_tb_top
`default_nettype wire
